// [verilog/lds_regs.vh]
`ifndef LDS_REGS_VH
`define LDS_REGS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LDS_ADDR_EVENT 8'h14
`define LDS_ADDR_MASK 8'h16
`define LDS_ADDR_CLEAR 8'h18
`define LDS_ADDR_PINCFG 8'h5c
`define LDS_ADDR_WETCFG 8'h98
// ----------------------------------------
// Register sizes in bytes
// ----------------------------------------
`define LDS_IRQ_BYTES 7'd8
`define LDS_PINCFG_BYTES 7'd44
`define LDS_WETCFG_BYTES 7'd11
// ----------------------------------------
// Reset values
// ----------------------------------------
`define LDS_MASK_RST 64'h0
`define LDS_PINCFG_RST 352'h0
`define LDS_WETCFG_RST 88'h0
// ----------------------------------------
// Interrupt event field
// ----------------------------------------
`define LDS_EVT_WET_BIT 60
// ----------------------------------------
// Pin function configuration fields
// ----------------------------------------
`define LDS_SENSE1_MUX_LSB 0
`define LDS_SENSE2_MUX_LSB 8
`define LDS_MUX_ADC 2'h1
`define LDS_SENSE1_ANA_BIT 228
`define LDS_SENSE2_ANA_BIT 229
`define LDS_FLAG_MAP_LSB 328
`define LDS_PU_MAP_LSB 336
`define LDS_PD_MAP_LSB 344
`define LDS_EVT_PU 8'h9b
`define LDS_EVT_PD 8'h9c
`define LDS_EVT_WET 8'h9d
// ----------------------------------------
// Wet sense configuration fields
// ----------------------------------------
`define LDS_SLEEP_DRY_LSB 0
`define LDS_SLEEP_WET_LSB 16
`define LDS_NSAMP_LSB 32
`define LDS_LO_EXIT_LSB 40
`define LDS_HI_EXIT_LSB 48
`define LDS_LO_ENTRY_LSB 56
`define LDS_HI_ENTRY_LSB 64
`define LDS_SETTLE_DRY_LSB 72
`define LDS_SETTLE_WET_LSB 76
`define LDS_STATE_BIT 80
`define LDS_CORR_BIT 81
`define LDS_ENABLE_BIT 82
// ----------------------------------------
// Timing
// ----------------------------------------
`define LDS_CLK_KHZ 125000
`define LDS_STEP_MS 10
`define LDS_STEP_CYCLES (`LDS_STEP_MS * `LDS_CLK_KHZ)
`define LDS_STEPS_PER_SEC 24'h64
`endif

// [verilog/lds_avg.v]
`timescale 1ns/1ps
// ----------------------------------------
// Sample accumulator with power-of-two mean
// ----------------------------------------
module lds_avg #(
    parameter DW = 8,
    parameter MAXE = 8
) (
    // Clock and reset
    input wire clk,
    input wire srst,
    // Sample stream
    input wire clear,
    input wire add,
    input wire [DW-1:0] din,
    input wire [3:0] exp_n,
    // Mean
    output wire [DW-1:0] avg
);
    localparam SW = DW + MAXE;

    reg [SW-1:0] sum;
    wire [SW-1:0] shifted;

    always @(posedge clk) begin
        if (srst || clear) begin
            sum <= {SW{1'b0}};
        end else if (add) begin
            sum <= sum + {{MAXE{1'b0}}, din};
        end
    end

    // Divide by the sample count; count is a power of two
    assign shifted = sum >> exp_n;
    assign avg = shifted[DW-1:0];
endmodule

// [verilog/lds_sampler.v]
`timescale 1ns/1ps
`include "lds_regs.vh"

module lds_sampler #(
    parameter STEP_CYCLES = `LDS_STEP_CYCLES,
    parameter MAXE = 8
) (
    // Clock and reset
    input wire clk,
    input wire srst,
    // Register port, one byte per access
    input wire [7:0] reg_addr,
    input wire [5:0] reg_byte,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire boot_done,
    // Interrupt
    output reg irq_n,
    // Converter
    output reg adc_req,
    output reg adc_chan,
    input wire adc_done,
    input wire [7:0] adc_data,
    // Pins
    output reg pullup_gate_pin,
    output reg pulldown_gate_pin,
    output reg wet_flag_pin,
    // Port power control
    output reg vbus_off,
    output reg cc_pulldown
);
    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam ST_SLEEP = 6'b000001;
    localparam ST_PU_SETTLE = 6'b000010;
    localparam ST_PU_SAMPLE = 6'b000100;
    localparam ST_PD_SETTLE = 6'b001000;
    localparam ST_PD_SAMPLE = 6'b010000;
    localparam ST_JUDGE = 6'b100000;
    localparam [20:0] STEP_LAST = STEP_CYCLES[20:0] - 21'h1;
    localparam [3:0] MAXE_W = MAXE[3:0];

    reg [5:0] st;
    reg [63:0] mask;
    reg [351:0] pincfg;
    reg [87:0] wetcfg;
    reg wet;
    reg wet_evt;
    reg corr_en;
    reg busy;
    reg [8:0] cnt;
    reg [23:0] wait_cnt;
    reg [20:0] div;

    wire step_tick = (div == STEP_LAST);
    wire wr_event = reg_wr && (reg_addr == `LDS_ADDR_CLEAR) && (reg_byte == 6'h7);
    wire evt_clr = wr_event && reg_wdata[`LDS_EVT_WET_BIT - 56];
    wire [63:0] event_vec = {3'h0, wet_evt, 60'h0};

    // ----------------------------------------
    // Configuration fields
    // ----------------------------------------
    wire [1:0] mux1 = pincfg[`LDS_SENSE1_MUX_LSB +: 2];
    wire [1:0] mux2 = pincfg[`LDS_SENSE2_MUX_LSB +: 2];
    wire route_ok = (mux1 == `LDS_MUX_ADC) && (mux2 == `LDS_MUX_ADC) &&
        pincfg[`LDS_SENSE1_ANA_BIT] && pincfg[`LDS_SENSE2_ANA_BIT];
    wire pu_map = (pincfg[`LDS_PU_MAP_LSB +: 8] == `LDS_EVT_PU);
    wire pd_map = (pincfg[`LDS_PD_MAP_LSB +: 8] == `LDS_EVT_PD);
    wire flag_map = (pincfg[`LDS_FLAG_MAP_LSB +: 8] == `LDS_EVT_WET);
    wire [15:0] sleep_dry = wetcfg[`LDS_SLEEP_DRY_LSB +: 16];
    wire [15:0] sleep_wet = wetcfg[`LDS_SLEEP_WET_LSB +: 16];
    wire [7:0] nsamp = wetcfg[`LDS_NSAMP_LSB +: 8];
    wire [7:0] lo_exit = wetcfg[`LDS_LO_EXIT_LSB +: 8];
    wire [7:0] hi_exit = wetcfg[`LDS_HI_EXIT_LSB +: 8];
    wire [7:0] lo_entry = wetcfg[`LDS_LO_ENTRY_LSB +: 8];
    wire [7:0] hi_entry = wetcfg[`LDS_HI_ENTRY_LSB +: 8];
    wire [3:0] settle_dry = wetcfg[`LDS_SETTLE_DRY_LSB +: 4];
    wire [3:0] settle_wet = wetcfg[`LDS_SETTLE_WET_LSB +: 4];

    // Exponents above the accumulator headroom are clamped
    wire [3:0] exp_n = (nsamp > {4'h0, MAXE_W}) ? MAXE_W : nsamp[3:0];
    wire [8:0] samp_last = (9'h1 << exp_n) - 9'h1;
    wire [3:0] settle = wet ? settle_wet : settle_dry;
    wire [15:0] sleep_s = wet ? sleep_wet : sleep_dry;
    wire [23:0] sleep_steps = {8'h0, sleep_s} * `LDS_STEPS_PER_SEC;

    // Hysteresis: the pair in force depends on the current state
    wire [7:0] lo_thr = wet ? lo_exit : lo_entry;
    wire [7:0] hi_thr = wet ? hi_exit : hi_entry;

    // ----------------------------------------
    // Averagers: high and low phase, both pins
    // ----------------------------------------
    wire acc_clr = (st == ST_SLEEP);
    wire take = busy && adc_done;
    wire add_h1 = take && (st == ST_PU_SAMPLE) && !adc_chan;
    wire add_h2 = take && (st == ST_PU_SAMPLE) && adc_chan;
    wire add_l1 = take && (st == ST_PD_SAMPLE) && !adc_chan;
    wire add_l2 = take && (st == ST_PD_SAMPLE) && adc_chan;
    wire [7:0] avg_h1;
    wire [7:0] avg_h2;
    wire [7:0] avg_l1;
    wire [7:0] avg_l2;

    lds_avg #(.DW(8), .MAXE(MAXE)) u_avg_h1 (
        .clk(clk), .srst(srst), .clear(acc_clr), .add(add_h1),
        .din(adc_data), .exp_n(exp_n), .avg(avg_h1)
    );
    lds_avg #(.DW(8), .MAXE(MAXE)) u_avg_h2 (
        .clk(clk), .srst(srst), .clear(acc_clr), .add(add_h2),
        .din(adc_data), .exp_n(exp_n), .avg(avg_h2)
    );
    lds_avg #(.DW(8), .MAXE(MAXE)) u_avg_l1 (
        .clk(clk), .srst(srst), .clear(acc_clr), .add(add_l1),
        .din(adc_data), .exp_n(exp_n), .avg(avg_l1)
    );
    lds_avg #(.DW(8), .MAXE(MAXE)) u_avg_l2 (
        .clk(clk), .srst(srst), .clear(acc_clr), .add(add_l2),
        .din(adc_data), .exp_n(exp_n), .avg(avg_l2)
    );

    // Codes compare raw: 0 is 0 V and ff is 3.3 V, linear between
    wire gnd_short = (avg_h1 < hi_thr) || (avg_h2 < hi_thr);
    wire pos_short = (avg_l1 > lo_thr) || (avg_l2 > lo_thr);
    wire next_wet = gnd_short || pos_short;

    // ----------------------------------------
    // Configuration writes
    // ----------------------------------------
    always @(posedge clk) begin
        if (srst) begin
            mask <= `LDS_MASK_RST;
            pincfg <= `LDS_PINCFG_RST;
            wetcfg <= `LDS_WETCFG_RST;
        end else if (reg_wr) begin
            if (reg_addr == `LDS_ADDR_MASK) begin
                // Taken at any time, though boot setup is the intended use
                if (reg_byte < `LDS_IRQ_BYTES) begin
                    mask[reg_byte * 8 +: 8] <= reg_wdata;
                end
            end else if (reg_addr == `LDS_ADDR_PINCFG) begin
                // Pin functions freeze once boot load is done
                if (!boot_done && reg_byte < `LDS_PINCFG_BYTES) begin
                    pincfg[reg_byte * 8 +: 8] <= reg_wdata;
                end
            end else if (reg_addr == `LDS_ADDR_WETCFG) begin
                if (reg_byte < `LDS_WETCFG_BYTES) begin
                    wetcfg[reg_byte * 8 +: 8] <= reg_wdata;
                end
            end
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    always @(posedge clk) begin
        if (srst) begin
            reg_rdata <= 8'h0;
        end else if (reg_rd) begin
            reg_rdata <= 8'h0;
            if (reg_addr == `LDS_ADDR_EVENT) begin
                if (reg_byte < `LDS_IRQ_BYTES) begin
                    reg_rdata <= event_vec[reg_byte * 8 +: 8];
                end
            end else if (reg_addr == `LDS_ADDR_MASK) begin
                if (reg_byte < `LDS_IRQ_BYTES) begin
                    reg_rdata <= mask[reg_byte * 8 +: 8];
                end
            end else if (reg_addr == `LDS_ADDR_PINCFG) begin
                if (reg_byte < `LDS_PINCFG_BYTES) begin
                    reg_rdata <= pincfg[reg_byte * 8 +: 8];
                end
            end else if (reg_addr == `LDS_ADDR_WETCFG) begin
                if (reg_byte == 6'ha) begin
                    reg_rdata <= {wetcfg[87:81], wet};
                end else if (reg_byte < `LDS_WETCFG_BYTES) begin
                    reg_rdata <= wetcfg[reg_byte * 8 +: 8];
                end
            end
        end
    end

    // ----------------------------------------
    // Event and interrupt
    // ----------------------------------------
    always @(posedge clk) begin
        if (srst) begin
            wet_evt <= 1'b0;
            irq_n <= 1'b1;
        end else begin
            // Set beats a clear landing in the same cycle
            if (st == ST_JUDGE && next_wet && !wet) begin
                wet_evt <= 1'b1;
            end else if (evt_clr) begin
                wet_evt <= 1'b0;
            end
            irq_n <= ~|(event_vec & mask);
        end
    end

    // ----------------------------------------
    // Sampling sequencer
    // ----------------------------------------
    always @(posedge clk) begin
        if (srst) begin
            st <= ST_SLEEP;
            wet <= 1'b0;
            corr_en <= 1'b0;
            busy <= 1'b0;
            cnt <= 9'h0;
            wait_cnt <= 24'h0;
            div <= 21'h0;
            adc_req <= 1'b0;
            adc_chan <= 1'b0;
            pullup_gate_pin <= 1'b0;
            pulldown_gate_pin <= 1'b0;
            wet_flag_pin <= 1'b0;
            vbus_off <= 1'b0;
            cc_pulldown <= 1'b0;
        end else begin
            adc_req <= 1'b0;
            div <= step_tick ? 21'h0 : div + 21'h1;
            if (step_tick && wait_cnt != 24'h0) begin
                wait_cnt <= wait_cnt - 24'h1;
            end
            wet_flag_pin <= wet && flag_map;
            vbus_off <= wet && corr_en;
            cc_pulldown <= wet && corr_en;
            case (st)
                ST_SLEEP: begin
                    if (wait_cnt == 24'h0) begin
                        // Policy run: enable and mitigation are read only here,
                        // so a write in mid-interval waits for the next run
                        corr_en <= wetcfg[`LDS_CORR_BIT];
                        div <= 21'h0;
                        if (wetcfg[`LDS_ENABLE_BIT] && route_ok) begin
                            pullup_gate_pin <= pu_map;
                            wait_cnt <= {20'h0, settle};
                            cnt <= 9'h0;
                            st <= ST_PU_SETTLE;
                        end else begin
                            // Disabled: leave any wet state and idle
                            wet <= 1'b0;
                            wait_cnt <= sleep_steps;
                        end
                    end
                end
                ST_PU_SETTLE: begin
                    if (wait_cnt == 24'h0) begin
                        adc_chan <= 1'b0;
                        st <= ST_PU_SAMPLE;
                    end
                end
                ST_PU_SAMPLE: begin
                    if (!busy) begin
                        adc_req <= 1'b1;
                        busy <= 1'b1;
                    end else if (adc_done) begin
                        busy <= 1'b0;
                        adc_chan <= ~adc_chan;
                        if (adc_chan) begin
                            cnt <= cnt + 9'h1;
                            if (cnt == samp_last) begin
                                // Pull-up off and pull-down on at the same edge
                                pullup_gate_pin <= 1'b0;
                                pulldown_gate_pin <= pd_map;
                                wait_cnt <= {20'h0, settle};
                                div <= 21'h0;
                                cnt <= 9'h0;
                                st <= ST_PD_SETTLE;
                            end
                        end
                    end
                end
                ST_PD_SETTLE: begin
                    if (wait_cnt == 24'h0) begin
                        adc_chan <= 1'b0;
                        st <= ST_PD_SAMPLE;
                    end
                end
                ST_PD_SAMPLE: begin
                    if (!busy) begin
                        adc_req <= 1'b1;
                        busy <= 1'b1;
                    end else if (adc_done) begin
                        busy <= 1'b0;
                        adc_chan <= ~adc_chan;
                        if (adc_chan) begin
                            cnt <= cnt + 9'h1;
                            if (cnt == samp_last) begin
                                pulldown_gate_pin <= 1'b0;
                                st <= ST_JUDGE;
                            end
                        end
                    end
                end
                ST_JUDGE: begin
                    // Averages settled on the last add, one cycle ago
                    wet <= next_wet;
                    if (next_wet) begin
                        wait_cnt <= {8'h0, sleep_wet} * `LDS_STEPS_PER_SEC;
                    end else begin
                        wait_cnt <= {8'h0, sleep_dry} * `LDS_STEPS_PER_SEC;
                    end
                    div <= 21'h0;
                    adc_chan <= 1'b0;
                    st <= ST_SLEEP;
                end
                default: begin
                    st <= ST_SLEEP;
                end
            endcase
        end
    end
endmodule

// [verif/lds_adc_model.sv]
`timescale 1ns/1ps
module lds_adc_model (
    // Clock
    input wire clk,
    // Converter handshake
    input wire adc_req,
    input wire adc_chan,
    output reg adc_done = 1'b0,
    output reg [7:0] adc_data = 8'h00,
    // Pull-up state and line codes {hi0, hi1, lo0, lo1}
    input wire pu,
    input wire [31:0] lvl
);
    integer hsum [0:1];
    integer lsum [0:1];
    integer hn = 0;
    integer cnt = 0;
    integer nint = 0;
    integer wt = 0;
    reg ch = 1'b0;
    reg hi = 1'b0;
    reg slow = 1'b0;
    reg pu_d = 1'b0;
    reg [7:0] v;
    always @(posedge clk) begin
        pu_d <= pu;
        adc_done <= 1'b0;
        // Data toggles outside a result so a stale code never looks valid
        adc_data <= ~adc_data;
        if (pu && !pu_d) begin
            hsum[0] = 0;
            hsum[1] = 0;
            lsum[0] = 0;
            lsum[1] = 0;
            hn = 0;
            cnt = 0;
            nint = nint + 1;
        end
        if (wt > 1) begin
            wt <= wt - 1;
        end else if (wt == 1) begin
            wt <= 0;
            // Linear code, one LSB of jitter on odd samples
            v = (hi ? lvl[31 - 8 * ch -: 8] : lvl[15 - 8 * ch -: 8]) + cnt % 2;
            adc_done <= 1'b1;
            adc_data <= v;
            if (hi) begin
                hsum[ch] = hsum[ch] + v;
                hn = hn + 1;
            end else begin
                lsum[ch] = lsum[ch] + v;
            end
            cnt = cnt + 1;
        end else if (adc_req) begin
            // Alternate a prompt and a slow answer
            ch <= adc_chan;
            hi <= pu;
            wt <= slow ? 4 : 1;
            slow <= !slow;
        end
    end
endmodule

// [verif/lds_sampler_chk.sv]
`timescale 1ns/1ps
`include "lds_regs.vh"
module lds_sampler_chk (
    // Clock and reset
    input wire clk,
    input wire srst,
    // Register port
    input wire [7:0] reg_addr,
    input wire [5:0] reg_byte,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    // Watched outputs
    input wire irq_n,
    input wire adc_req,
    input wire adc_chan,
    input wire adc_done,
    input wire pullup_gate_pin,
    input wire pulldown_gate_pin,
    input wire wet_flag_pin,
    input wire vbus_off,
    input wire cc_pulldown
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    reg busy = 1'b0;
    reg mask60 = 1'b0;
    wire b7 = reg_wr && reg_byte == 6'd7;
    wire clr_w = b7 && reg_wdata[4] && reg_addr == `LDS_ADDR_CLEAR;
    wire msk_w = b7 && reg_addr == `LDS_ADDR_MASK;
    always @(posedge clk) begin
        if (srst) begin
            busy <= 1'b0;
            mask60 <= 1'b0;
        end else begin
            busy <= adc_req ? 1'b1 : (adc_done ? 1'b0 : busy);
            mask60 <= msk_w ? reg_wdata[4] : mask60;
        end
    end
    // A clear on the judging edge loses to a new event, so that edge is left out
    sequence s_clr; clr_w && !$past(adc_done); endsequence
    sequence s_irq_up; ##2 irq_n; endsequence
    property p_clear; s_clr |-> s_irq_up; endproperty
    a_clear: assert property (p_clear) else $error("irq held after clear");
    property p_hold; !irq_n && !clr_w && !$past(clr_w) && !msk_w && !$past(msk_w) |=> !irq_n;
    endproperty
    a_hold: assert property (p_hold) else $error("irq released without clear");
    property p_flag_irq; $rose(wet_flag_pin) && mask60 |-> ##[0:1] !irq_n; endproperty
    a_flag_irq: assert property (p_flag_irq) else $error("wet without irq");
    property p_excl; !(pullup_gate_pin && pulldown_gate_pin); endproperty
    a_excl: assert property (p_excl) else $error("both gates on");
    property p_req_gate; adc_req |-> (pullup_gate_pin ^ pulldown_gate_pin) && !busy; endproperty
    a_req_gate: assert property (p_req_gate) else $error("sample without pull");
    property p_chan; busy && !adc_done |=> $stable(adc_chan); endproperty
    a_chan: assert property (p_chan) else $error("channel moved");
    property p_mit; vbus_off == cc_pulldown; endproperty
    a_mit: assert property (p_mit) else $error("vbus and cc differ");
    property p_mit_wet; $rose(vbus_off) |-> ##[0:1] wet_flag_pin; endproperty
    a_mit_wet: assert property (p_mit_wet) else $error("port off while dry");
    property p_rdata; !reg_rd |=> $stable(reg_rdata); endproperty
    a_rdata: assert property (p_rdata) else $error("read data moved");
endmodule
bind lds_sampler lds_sampler_chk lds_sampler_chk_inst (.clk, .srst, .reg_addr, .reg_byte,
    .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .irq_n, .adc_req, .adc_chan, .adc_done,
    .pullup_gate_pin, .pulldown_gate_pin, .wet_flag_pin, .vbus_off, .cc_pulldown);

// [verif/tb.sv]
`timescale 1ns/1ps
`include "lds_regs.vh"
module tb;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    reg clk = 1'b0;
    reg srst = 1'b1;
    reg [7:0] reg_addr = 8'h00;
    reg [5:0] reg_byte = 6'h00;
    reg reg_wr = 1'b0;
    reg [7:0] reg_wdata = 8'h00;
    reg reg_rd = 1'b0;
    reg boot_done = 1'b0;
    reg [31:0] lvl = 32'hf0f01010;
    wire [7:0] reg_rdata;
    wire [7:0] adc_data;
    wire irq_n, adc_req, adc_chan, adc_done;
    wire pullup_gate_pin, pulldown_gate_pin, wet_flag_pin, vbus_off, cc_pulldown;
    integer err_total = 0;
    integer checks = 0;
    integer cyc = 0;
    integer t_end = 0;
    integer i;
    integer k;
    reg wet_m = 1'b0;
    reg evt_m = 1'b0;
    reg [7:0] rd;
    // Low exit <= low entry, high entry <= high exit
    localparam [87:0] CFG = {8'h07, 8'h21, 8'hc0, 8'h40, 8'he0, 8'h20, 8'h03, 16'h2, 16'h1};
    localparam [35:0] PB = {6'd43, 6'd42, 6'd41, 6'd28, 6'd1, 6'd0};
    localparam [47:0] PV = 48'h9c9b9d300101;
    localparam [223:0] TAB = {32'hf0f03010, 32'hf0f04110, 32'hf0f03010, 32'hf0f01010,
        32'hf0c01010, 32'hf0bf1010, 32'hf0f01010};
    lds_sampler #(.STEP_CYCLES(20)) lds_sampler_inst (.clk, .srst, .reg_addr, .reg_byte,
        .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .boot_done, .irq_n, .adc_req, .adc_chan,
        .adc_done, .adc_data, .pullup_gate_pin, .pulldown_gate_pin, .wet_flag_pin, .vbus_off,
        .cc_pulldown);
    lds_adc_model lds_adc_model_inst (.clk, .adc_req, .adc_chan, .adc_done, .adc_data,
        .pu(pullup_gate_pin), .lvl);
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            err_total = err_total + 1;
            print_verdict;
        end
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task tick;
        begin
            @(posedge clk);
            #1;
        end
    endtask
    task check(input [63:0] seen, input [63:0] exp, input [8*10-1:0] what);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("[FAIL] %0s expected %0h seen %0h", what, exp, seen);
            end
        end
    endtask
    task wr(input [7:0] a, input [5:0] b, input [7:0] d);
        begin
            @(posedge clk);
            reg_addr <= a;
            reg_byte <= b;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge clk);
            reg_wr <= 1'b0;
        end
    endtask
    task rdb(input [7:0] a, input [5:0] b);
        begin
            @(posedge clk);
            reg_addr <= a;
            reg_byte <= b;
            reg_rd <= 1'b1;
            @(posedge clk);
            reg_rd <= 1'b0;
            #1;
            rd = reg_rdata;
        end
    endtask
    task clr;
        begin
            wr(`LDS_ADDR_CLEAR, 7, 8'h10);
            repeat (3) tick;
            evt_m = 1'b0;
            check(irq_n, 1'b1, "irq_clr");
            rdb(`LDS_ADDR_EVENT, 7);
            check(rd, 8'h00, "evt_clr");
        end
    endtask
    function automatic [7:0] rv();
        rv = $urandom % 255;
    endfunction
    // One sampling interval against the reference state
    task interval(input [31:0] v);
        integer t0;
        integer c;
        integer sl;
        reg sh;
        begin
            lvl = v;
            sl = wet_m ? 4000 : 2000;
            t0 = 0;
            while (pullup_gate_pin !== 1'b1 && t0 < 9000) begin
                tick;
                t0 = t0 + 1;
            end
            if (t_end > 0) check(cyc - t_end >= sl && cyc - t_end <= sl + 16, 1, "sleep");
            t0 = cyc;
            while (adc_req !== 1'b1 && cyc - t0 < 200) tick;
            sl = wet_m ? 40 : 20;
            check(cyc - t0 >= sl && cyc - t0 <= sl + 4, 1, "settle");
            t0 = 0;
            while (lds_adc_model_inst.cnt < 32 && t0 < 2000) begin
                tick;
                t0 = t0 + 1;
            end
            repeat (10) tick;
            t_end = cyc - 10;
            check(lds_adc_model_inst.hn, 16, "hi_count");
            check(lds_adc_model_inst.cnt, 32, "count");
            sh = 1'b0;
            for (c = 0; c < 2; c = c + 1) begin
                // Exit pair while wet, entry pair while dry
                if (wet_m) sh = sh | (lds_adc_model_inst.hsum[c] / 8 < CFG[55:48])
                    | (lds_adc_model_inst.lsum[c] / 8 > CFG[47:40]);
                else sh = sh | (lds_adc_model_inst.hsum[c] / 8 < CFG[71:64])
                    | (lds_adc_model_inst.lsum[c] / 8 > CFG[63:56]);
            end
            evt_m = evt_m | (sh & !wet_m);
            wet_m = sh;
            check(wet_flag_pin, wet_m, "flag");
            check({vbus_off, cc_pulldown}, {2{wet_m}}, "mitigate");
            check(irq_n, !evt_m, "irq");
            rdb(`LDS_ADDR_WETCFG, 10);
            check(rd, {7'h03, wet_m}, "state");
            rdb(`LDS_ADDR_EVENT, 7);
            check(rd, {3'h0, evt_m, 4'h0}, "event");
        end
    endtask
    task print_verdict;
        begin
            $display("checks %0d errors %0d", checks, err_total);
            if (err_total == 0 && checks > 0) begin
                $display("Simulation passed");
            end else begin
                $display("Simulation failed");
            end
            $finish;
        end
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        k = $urandom(32'ha194);
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        rdb(`LDS_ADDR_MASK, 7);
        check(rd, 8'h00, "mask_rst");
        rdb(`LDS_ADDR_WETCFG, 10);
        check(rd, 8'h00, "cfg_rst");
        for (k = 0; k < 6; k = k + 1) wr(`LDS_ADDR_PINCFG, PB[k*6+:6], PV[k*8+:8]);
        boot_done <= 1'b1;
        wr(`LDS_ADDR_PINCFG, 41, 8'h00);
        rdb(`LDS_ADDR_PINCFG, 41);
        check(rd, 8'h9d, "pin_lock");
        wr(`LDS_ADDR_MASK, 7, 8'h10);
        rdb(`LDS_ADDR_MASK, 7);
        check(rd, 8'h10, "mask");
        wr(`LDS_ADDR_EVENT, 7, 8'hff);
        rdb(`LDS_ADDR_EVENT, 7);
        check(rd, 8'h00, "evt_ro");
        rdb(`LDS_ADDR_CLEAR, 7);
        check(rd, 8'h00, "clr_wo");
        rdb(8'h20, 0);
        check(rd, 8'h00, "unmapped");
        for (k = 0; k < 11; k = k + 1) wr(`LDS_ADDR_WETCFG, k, CFG[k*8+:8]);
        rdb(`LDS_ADDR_WETCFG, 10);
        check(rd, 8'h06, "ro_state");
        for (i = 0; i < 7; i = i + 1) begin
            interval(TAB[i*32+:32]);
            if (i == 3) clr;
        end
        for (i = 0; i < 5; i = i + 1) interval({rv(), rv(), rv(), rv()});
        clr;
        wr(`LDS_ADDR_WETCFG, 10, 8'h00);
        k = lds_adc_model_inst.nint;
        repeat (6000) tick;
        check(lds_adc_model_inst.nint, k, "disabled");
        check({wet_flag_pin, irq_n}, 2'b01, "dis_out");
        print_verdict;
    end
endmodule
